// ### bof_pkg.sv
// package and shift/rotate datapath for the bit-ops and flag execution unit
// ==========================================================================
// Behaviour
// - branch when overflow clear, 1/2 cycles
// - branch when global interrupt flag set
// - branch when global interrupt flag clear
// - set one io register bit, 2 cycles
// - clear one io register bit, 2 cycles
// - shift left, zero in, flags updated
// - shift right, zero in, flags updated
// - rotate left through carry, flags updated
// - rotate right through carry, flags updated
// - arithmetic right shift keeps bit seven
// - set one named flag only, 1 cycle
// - clear one named flag only, 1 cycle
// - copy register bit into transfer flag
// - copy transfer flag into register bit
// - register and pair copy, no flags
package bof_pkg;
  // ========================================================================
  // register map
  localparam logic [11:0] OFS_CMD      = 12'h000;
  localparam logic [11:0] OFS_STATUS   = 12'h004;
  localparam logic [11:0] OFS_FLAGS    = 12'h008;
  localparam logic [11:0] OFS_PC       = 12'h00C;
  localparam logic [3:0]  OFS_GPR_PAGE = 4'h1;
  localparam logic [3:0]  OFS_IO_PAGE  = 4'h2;
  localparam logic [7:0]  RST_FLAGS    = 8'h00;
  localparam logic [15:0] RST_PC       = 16'h0000;
  localparam logic [7:0]  RST_BYTE     = 8'h00;
  // ========================================================================
  // flag register bit positions
  localparam int unsigned FLG_C = 0;
  localparam int unsigned FLG_Z = 1;
  localparam int unsigned FLG_N = 2;
  localparam int unsigned FLG_V = 3;
  localparam int unsigned FLG_S = 4;
  localparam int unsigned FLG_H = 5;
  localparam int unsigned FLG_T = 6;
  localparam int unsigned FLG_I = 7;
  // ========================================================================
  // status register fields
  localparam int unsigned STS_BUSY  = 0;
  localparam int unsigned STS_TAKEN = 1;
  localparam int unsigned STS_CYC   = 2;
  // ========================================================================
  // instruction cycle counts
  localparam logic [1:0] CYC_SINGLE       = 2'd1;
  localparam logic [1:0] CYC_IO_BIT       = 2'd2;
  localparam logic [1:0] CYC_BRANCH_TAKEN = 2'd2;
  // ========================================================================
  // types
  typedef enum logic [4:0] {
    OP_NOP                   = 5'h00,
    OP_BRANCH_OVERFLOW_CLEAR = 5'h01,
    OP_BRANCH_IRQ_ENABLED    = 5'h02,
    OP_BRANCH_IRQ_DISABLED   = 5'h03,
    OP_IO_BIT_SET            = 5'h04,
    OP_IO_BIT_CLEAR          = 5'h05,
    OP_SHIFT_LEFT_LOGICAL    = 5'h06,
    OP_SHIFT_RIGHT_LOGICAL   = 5'h07,
    OP_ROTATE_LEFT_CARRY     = 5'h08,
    OP_ROTATE_RIGHT_CARRY    = 5'h09,
    OP_SHIFT_RIGHT_ARITH     = 5'h0A,
    OP_SWAP_NIBBLES          = 5'h0B,
    OP_FLAG_SET_GENERIC      = 5'h0C,
    OP_FLAG_CLEAR_GENERIC    = 5'h0D,
    OP_BIT_TO_TRANSFER_FLAG  = 5'h0E,
    OP_TRANSFER_FLAG_TO_BIT  = 5'h0F,
    OP_GLOBAL_IRQ_ON         = 5'h10,
    OP_GLOBAL_IRQ_OFF        = 5'h11,
    OP_REG_COPY              = 5'h12,
    OP_REG_PAIR_COPY         = 5'h13
  } bof_op_type;

  typedef struct packed {
    logic [6:0] offset;
    logic [4:0] io_addr;
    logic [2:0] bit_sel;
    logic [4:0] src;
    logic [4:0] dst;
    bof_op_type op;
  } bof_cmd_type;

  typedef struct packed {
    logic [7:0] value;
    logic [7:0] flags;
  } bof_alu_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_HOLD = 2'b11
  } bof_state_type;
endpackage

`timescale 1ns/1ps
// ==========================================================================
// shift and rotate datapath; flags other than z, c, n, v pass through
module bof_shift_unit
  import bof_pkg::*;
(
  input  wire bof_op_type  op,
  input  wire logic [7:0]  value,
  input  wire logic [7:0]  flags_in,
  output bof_alu_type      result
);
  logic [7:0] res;
  logic       cout;
  logic       neg;

  always_comb begin
    res  = value;
    cout = flags_in[FLG_C];
    unique case (op)
      OP_SHIFT_LEFT_LOGICAL: begin
        res  = {value[6:0], 1'b0};
        cout = value[7];
      end
      OP_SHIFT_RIGHT_LOGICAL: begin
        res  = {1'b0, value[7:1]};
        cout = value[0];
      end
      OP_ROTATE_LEFT_CARRY: begin
        res  = {value[6:0], flags_in[FLG_C]};
        cout = value[7];
      end
      OP_ROTATE_RIGHT_CARRY: begin
        res  = {flags_in[FLG_C], value[7:1]};
        cout = value[0];
      end
      OP_SHIFT_RIGHT_ARITH: begin
        res  = {value[7], value[7:1]};
        cout = value[0];
      end
      default: begin
        res  = value;
        cout = flags_in[FLG_C];
      end
    endcase
    neg                  = res[7];
    result.value         = res;
    result.flags         = flags_in;
    result.flags[FLG_Z]  = (res == 8'h00);
    result.flags[FLG_C]  = cout;
    result.flags[FLG_N]  = neg;
    // overflow as n xor c after the shift, as for every shift of this family
    result.flags[FLG_V]  = neg ^ cout;
  end
endmodule

// ### bof_unit.sv
// top of the bit-ops and flag execution unit with its apb register slave
//
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/1ps
module bof_unit
  import bof_pkg::*;
#(
  parameter int unsigned IO_REGS = 32
)(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             exec_busy,
  output logic      [7:0]  flag_register,
  output logic      [15:0] pc_out
);
  // ========================================================================
  // storage
  // instructions carry a five-bit io address, so io entries 32 to 63 are reachable from the bus only and entries past 63 from neither
  localparam int unsigned GPRS  = 32;
  localparam int unsigned IO_AW = (IO_REGS > 1) ? $clog2(IO_REGS) : 1;
  logic          [7:0]  gpr_ff [GPRS];
  logic          [7:0]  io_ff [IO_REGS];
  logic          [7:0]  flags_ff;
  logic          [15:0] pc_ff;
  bof_cmd_type          cmd_ff;
  bof_state_type        state_ff;
  logic                 taken_ff;
  logic          [1:0]  cyc_ff;
  logic          [31:0] prdata_ff;
  logic                 pready_ff;
  logic                 pslverr_ff;

  // ========================================================================
  // apb decode
  logic       access;
  logic       fire_wr;
  logic [5:0] word_idx;
  logic [4:0] gpr_bus_idx;
  logic [IO_AW-1:0] io_bus_idx;
  logic       answer;
  logic       hit_cmd;
  logic       hit_status;
  logic       hit_flags;
  logic       hit_pc;
  logic       hit_gpr;
  logic       hit_io;
  logic       mapped;
  logic       stall;
  logic [31:0] nxt_prdata;

  assign access     = psel & penable;
  assign fire_wr    = access & pwrite & pready_ff;
  assign word_idx   = paddr[7:2];
  assign gpr_bus_idx = word_idx[4:0];
  // io index cut to the bank's own width; hit_io has already checked the range
  assign io_bus_idx = IO_AW'(word_idx);
  assign hit_cmd    = (paddr == OFS_CMD);
  assign hit_status = (paddr == OFS_STATUS);
  assign hit_flags  = (paddr == OFS_FLAGS);
  assign hit_pc     = (paddr == OFS_PC);
  assign hit_gpr    = (paddr[11:8] == OFS_GPR_PAGE) && (paddr[1:0] == 2'b00) && !paddr[7];
  assign hit_io     = (paddr[11:8] == OFS_IO_PAGE) && (paddr[1:0] == 2'b00) &&
                      (32'(word_idx) < IO_REGS);
  assign mapped     = hit_cmd | hit_status | hit_flags | hit_pc | hit_gpr | hit_io;
  // writes wait while an instruction runs, so bus and execution never collide
  assign stall      = pwrite & (state_ff != ST_IDLE);
  // the one edge that launches pready; read data is captured at the same edge
  assign answer     = access & !pready_ff & !stall;

  always_comb begin
    nxt_prdata = 32'h0000_0000;
    if (hit_cmd) begin
      nxt_prdata = {2'b00, cmd_ff};
    end else if (hit_status) begin
      nxt_prdata[STS_BUSY]              = (state_ff != ST_IDLE);
      nxt_prdata[STS_TAKEN]             = taken_ff;
      nxt_prdata[STS_CYC +: 2]          = cyc_ff;
    end else if (hit_flags) begin
      nxt_prdata[7:0] = flags_ff;
    end else if (hit_pc) begin
      nxt_prdata[15:0] = pc_ff;
    end else if (hit_gpr) begin
      nxt_prdata[7:0] = gpr_ff[gpr_bus_idx];
    end else if (hit_io) begin
      nxt_prdata[7:0] = io_ff[io_bus_idx];
    end
  end

  // one wait state: ready and read data are registered together
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else begin
      pready_ff  <= answer;
      pslverr_ff <= answer & !mapped;
      if (answer) begin
        prdata_ff <= nxt_prdata;
      end
    end
  end

  // ========================================================================
  // execution datapath
  logic        [7:0]  rd_val;
  logic        [7:0]  rr_val;
  logic        [7:0]  io_val;
  logic [IO_AW-1:0]   io_ex_idx;
  logic               io_ex_ok;
  bof_alu_type        shift_res;
  logic               take;
  logic        [1:0]  nxt_cyc;
  logic        [7:0]  nxt_flags;
  logic               ex_flags_we;
  logic               ex_a_we;
  logic        [4:0]  ex_a_idx;
  logic        [7:0]  ex_a_dat;
  logic               ex_b_we;
  logic        [4:0]  ex_b_idx;
  logic        [7:0]  ex_b_dat;
  logic               ex_io_we;
  logic        [7:0]  ex_io_dat;
  logic               commit;

  assign rd_val = gpr_ff[cmd_ff.dst];
  assign rr_val = gpr_ff[cmd_ff.src];
  assign io_ex_ok  = (32'(cmd_ff.io_addr) < IO_REGS);
  assign io_ex_idx = IO_AW'(cmd_ff.io_addr);
  assign io_val    = io_ex_ok ? io_ff[io_ex_idx] : 8'h00;
  assign commit = (state_ff == ST_EXEC);

  bof_shift_unit u_shift (
    .op       (cmd_ff.op),
    .value    (rd_val),
    .flags_in (flags_ff),
    .result   (shift_res)
  );

  always_comb begin
    take        = 1'b0;
    nxt_cyc     = CYC_SINGLE;
    nxt_flags   = flags_ff;
    ex_flags_we = 1'b0;
    ex_a_we     = 1'b0;
    ex_a_idx    = cmd_ff.dst;
    ex_a_dat    = rd_val;
    ex_b_we     = 1'b0;
    ex_b_idx    = cmd_ff.dst;
    ex_b_dat    = rd_val;
    ex_io_we    = 1'b0;
    ex_io_dat   = io_val;
    unique case (cmd_ff.op)
      OP_BRANCH_OVERFLOW_CLEAR: begin
        take = !flags_ff[FLG_V];
      end
      OP_BRANCH_IRQ_ENABLED: begin
        take = flags_ff[FLG_I];
      end
      OP_BRANCH_IRQ_DISABLED: begin
        take = !flags_ff[FLG_I];
      end
      OP_IO_BIT_SET: begin
        nxt_cyc                  = CYC_IO_BIT;
        ex_io_we                 = io_ex_ok;
        ex_io_dat[cmd_ff.bit_sel] = 1'b1;
      end
      OP_IO_BIT_CLEAR: begin
        nxt_cyc                  = CYC_IO_BIT;
        ex_io_we                 = io_ex_ok;
        ex_io_dat[cmd_ff.bit_sel] = 1'b0;
      end
      OP_SHIFT_LEFT_LOGICAL, OP_SHIFT_RIGHT_LOGICAL, OP_ROTATE_LEFT_CARRY,
      OP_ROTATE_RIGHT_CARRY, OP_SHIFT_RIGHT_ARITH: begin
        ex_a_we     = 1'b1;
        ex_a_dat    = shift_res.value;
        ex_flags_we = 1'b1;
        nxt_flags   = shift_res.flags;
      end
      OP_SWAP_NIBBLES: begin
        ex_a_we  = 1'b1;
        ex_a_dat = {rd_val[3:0], rd_val[7:4]};
      end
      OP_FLAG_SET_GENERIC: begin
        ex_flags_we                = 1'b1;
        nxt_flags[cmd_ff.bit_sel]  = 1'b1;
      end
      OP_FLAG_CLEAR_GENERIC: begin
        ex_flags_we                = 1'b1;
        nxt_flags[cmd_ff.bit_sel]  = 1'b0;
      end
      OP_BIT_TO_TRANSFER_FLAG: begin
        ex_flags_we      = 1'b1;
        nxt_flags[FLG_T] = rr_val[cmd_ff.bit_sel];
      end
      OP_TRANSFER_FLAG_TO_BIT: begin
        ex_a_we                  = 1'b1;
        ex_a_dat[cmd_ff.bit_sel] = flags_ff[FLG_T];
      end
      OP_GLOBAL_IRQ_ON: begin
        ex_flags_we      = 1'b1;
        nxt_flags[FLG_I] = 1'b1;
      end
      OP_GLOBAL_IRQ_OFF: begin
        ex_flags_we      = 1'b1;
        nxt_flags[FLG_I] = 1'b0;
      end
      OP_REG_COPY: begin
        ex_a_we  = 1'b1;
        ex_a_dat = rr_val;
      end
      OP_REG_PAIR_COPY: begin
        // pair indices are forced even, the odd register is the high byte
        ex_a_we  = 1'b1;
        ex_a_idx = {cmd_ff.dst[4:1], 1'b0};
        ex_a_dat = gpr_ff[{cmd_ff.src[4:1], 1'b0}];
        ex_b_we  = 1'b1;
        ex_b_idx = {cmd_ff.dst[4:1], 1'b1};
        ex_b_dat = gpr_ff[{cmd_ff.src[4:1], 1'b1}];
      end
      default: begin
        take = 1'b0;
      end
    endcase
    if (take) begin
      nxt_cyc = CYC_BRANCH_TAKEN;
    end
  end

  // ========================================================================
  // sequencer: exec commits, hold adds the second cycle where needed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= ST_IDLE;
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          if (fire_wr && hit_cmd) begin
            state_ff <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          state_ff <= (nxt_cyc == CYC_SINGLE) ? ST_IDLE : ST_HOLD;
        end
        ST_HOLD: begin
          state_ff <= ST_IDLE;
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_ff <= '0;
    end else if (fire_wr && hit_cmd) begin
      cmd_ff <= bof_cmd_type'(pwdata[29:0]);
    end
  end

  // status keeps the outcome of the last instruction until the next one commits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      taken_ff <= 1'b0;
      cyc_ff   <= 2'b00;
    end else if (commit) begin
      taken_ff <= take;
      cyc_ff   <= nxt_cyc;
    end
  end

  // only flag-writing instructions touch the flags; branches and moves never do
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_ff <= RST_FLAGS;
    end else if (commit && ex_flags_we) begin
      flags_ff <= nxt_flags;
    end else if (fire_wr && hit_flags) begin
      flags_ff <= pwdata[7:0];
    end
  end

  // the offset is a signed seven-bit value; the counter simply wraps at 16 bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_ff <= RST_PC;
    end else if (commit) begin
      if (take) begin
        pc_ff <= pc_ff + {{9{cmd_ff.offset[6]}}, cmd_ff.offset} + 16'h0001;
      end else begin
        pc_ff <= pc_ff + 16'h0001;
      end
    end else if (fire_wr && hit_pc) begin
      pc_ff <= pwdata[15:0];
    end
  end

  // ========================================================================
  // register file and io bank, one process per entry
  for (genvar gi = 0; gi < GPRS; gi++) begin : g_gpr
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        gpr_ff[gi] <= RST_BYTE;
      end else if (commit && ex_a_we && (ex_a_idx == 5'(gi))) begin
        gpr_ff[gi] <= ex_a_dat;
      end else if (commit && ex_b_we && (ex_b_idx == 5'(gi))) begin
        gpr_ff[gi] <= ex_b_dat;
      end else if (fire_wr && hit_gpr && (gpr_bus_idx == 5'(gi))) begin
        gpr_ff[gi] <= pwdata[7:0];
      end
    end
  end

  // io writes land on the first edge; the second cycle is a hold
  for (genvar gj = 0; gj < IO_REGS; gj++) begin : g_io
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        io_ff[gj] <= RST_BYTE;
      end else if (commit && ex_io_we && (32'(cmd_ff.io_addr) == gj)) begin
        io_ff[gj] <= ex_io_dat;
      end else if (fire_wr && hit_io && (32'(word_idx) == gj)) begin
        io_ff[gj] <= pwdata[7:0];
      end
    end
  end

  // ========================================================================
  // outputs
  assign prdata        = prdata_ff;
  assign pready        = pready_ff;
  assign pslverr       = pslverr_ff;
  assign exec_busy     = state_ff[0];
  assign flag_register = flags_ff;
  assign pc_out        = pc_ff;
endmodule

// ### bof_unit_sva.sv
// assertion checker for the bit-ops and flag unit, bound to its top
`timescale 1ns/1ps
module bof_unit_sva
  import bof_pkg::*;
#(
  parameter int unsigned IO_REGS = 32
)(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        exec_busy,
  input wire logic [7:0]  flag_register,
  input wire logic [15:0] pc_out
);
  // ====================
  // accepted command and its expected outcome; flags cannot move while busy since writes stall
  wire logic        acc = psel & penable & pready & pwrite & (paddr == OFS_CMD);
  wire logic [4:0]  op  = pwdata[4:0];
  wire logic [7:0]  msk = 8'h01 << pwdata[17:15];
  wire logic        ion = (op == OP_GLOBAL_IRQ_ON);
  wire logic        tkn = (op == 5'h01) ? !flag_register[FLG_V] : (op == 5'h02) ? flag_register[FLG_I] :
                          (op == 5'h03) ? !flag_register[FLG_I] : 1'b0;
  wire logic        lng = tkn | (op == 5'h04) | (op == 5'h05);
  wire logic [15:0] xpc = pc_out + 16'h0001 + (tkn ? {{9{pwdata[29]}}, pwdata[29:23]} : 16'h0000);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ====================
  // results show two edges after the command is taken
  a_pc_update: assert property (acc |-> ##2 pc_out == $past(xpc, 2))
    else $error("program counter wrong after command");
  a_busy_length: assert property (acc |=> exec_busy ##1 (exec_busy == $past(lng, 2)))
    else $error("busy length wrong for command");
  a_busy_bound: assert property (exec_busy [*2] |=> !exec_busy)
    else $error("busy longer than two cycles");
  a_flags_kept: assert property (acc && op inside {[1:5], 11, 15, 18, 19} |-> ##2
    flag_register == $past(flag_register, 2)) else $error("flags changed by flag-neutral command");
  a_shift_flags: assert property (acc && op inside {[6:10]} |-> ##2
    (flag_register[FLG_V] == (flag_register[FLG_N] ^ flag_register[FLG_C])) &&
    ((flag_register & 8'hF0) == ($past(flag_register, 2) & 8'hF0))) else $error("shift flags wrong");
  a_flag_set: assert property (acc && op == OP_FLAG_SET_GENERIC |-> ##2
    flag_register == ($past(flag_register, 2) | $past(msk, 2))) else $error("flag set wrong");
  a_flag_clear: assert property (acc && op == OP_FLAG_CLEAR_GENERIC |-> ##2
    flag_register == ($past(flag_register, 2) & ~$past(msk, 2))) else $error("flag clear wrong");
  a_irq_flag: assert property (acc && op inside {16, 17} |-> ##2 flag_register[FLG_I] == $past(ion, 2) &&
    ((flag_register ^ $past(flag_register, 2)) & 8'h7F) == 8'h00) else $error("interrupt flag op wrong");
  a_t_only: assert property (acc && op == OP_BIT_TO_TRANSFER_FLAG |-> ##2
    ((flag_register ^ $past(flag_register, 2)) & 8'hBF) == 8'h00) else $error("bit store touched other flags");
endmodule

bind bof_unit bof_unit_sva #(.IO_REGS(IO_REGS)) u_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .exec_busy(exec_busy),
  .flag_register(flag_register), .pc_out(pc_out)
);

// ### tb_bof_unit.sv
// self-checking bench for the bit-ops and flag unit over its apb port
`timescale 1ns/1ps
module tb_bof_unit
  import bof_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, exec_busy, lerr, t;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  flag_register, v, f;
  logic [15:0] pc_out;
  bof_alu_type e;
  int          n_mismatch = 0;
  int          checks_done = 0;

  bof_unit dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .exec_busy(exec_busy),
    .flag_register(flag_register), .pc_out(pc_out)
  );

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // ====================
  // checking and bus tasks
  task automatic conclude;
    if (n_mismatch == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    checks_done++;
    if (s !== x) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, x, s);
    end
  endtask
  // hold keeps psel up so the next setup follows at once, which lets a write meet a busy unit
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic hold);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (pready !== 1'b1) begin
      n_mismatch++;
      conclude();
    end
    rd = prdata;
    lerr = pslverr;
    penable <= 1'b0;
    if (!hold) begin
      psel <= 1'b0;
      @(posedge pclk);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 1'b0);
  endtask
  task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] x);
    xfer(1'b0, a, 32'h0000_0000, 1'b0);
    chk(nm, rd, x);
  endtask
  // reads never stall, so results are only read once busy is gone
  task automatic exe(input logic [31:0] c);
    int k;
    wr(OFS_CMD, c);
    k = 0;
    while (exec_busy !== 1'b0 && k < 8) begin
      @(posedge pclk);
      k++;
    end
    if (exec_busy !== 1'b0) begin
      n_mismatch++;
      conclude();
    end
  endtask
  function automatic logic [31:0] cw(input logic [4:0] op, ds, sr, input logic [2:0] b, input logic [4:0] io,
                                     input logic [6:0] off);
    bof_cmd_type c;
    c = {off, io, b, sr, ds, op};
    return {2'b00, c};
  endfunction
  function automatic logic [11:0] ad(input logic [3:0] pg, input int i);
    return {pg, i[5:0], 2'b00};
  endfunction
  // expected shift outcome; s, h, t and i pass through
  function automatic bof_alu_type shm(input logic [4:0] op, input logic [7:0] x, input logic [7:0] g);
    logic [7:0] r;
    logic       c;
    c = (op == 5'h06 || op == 5'h08) ? x[7] : x[0];
    case (op)
      5'h06: r = {x[6:0], 1'b0};
      5'h07: r = {1'b0, x[7:1]};
      5'h08: r = {x[6:0], g[FLG_C]};
      5'h09: r = {g[FLG_C], x[7:1]};
      5'h0A: r = {x[7], x[7:1]};
      default: r = {x[3:0], x[7:4]};
    endcase
    if (op != 5'h0B) begin
      g[FLG_C] = c;
      g[FLG_Z] = (r == 8'h00);
      g[FLG_N] = r[7];
      g[FLG_V] = r[7] ^ c;
    end
    return {r, g};
  endfunction
  // ====================
  // main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("flags_reset", 32'(flag_register), 32'(RST_FLAGS));
    chk("pc_reset", 32'(pc_out), 32'(RST_PC));
    rchk("unmapped_rd", 12'h010, 32'h0000_0000);
    chk("unmapped_err", 32'(lerr), 32'h0000_0001);
    wr(12'h00D, 32'h0000_00FF);
    chk("unaligned_err", 32'(lerr), 32'h0000_0001);
    rchk("pc_kept", OFS_PC, 32'h0000_0000);
    chk("mapped_err", 32'(lerr), 32'h0000_0000);
    for (int o = 6; o < 12; o++) begin
      for (int i = 0; i < 4; i++) begin
        v = i[0] ? 8'h80 : 8'h96;
        f = i[1] ? 8'hF1 : 8'h00;
        e = shm(o[4:0], v, f);
        wr(ad(OFS_GPR_PAGE, 3), 32'(v));
        wr(OFS_FLAGS, 32'(f));
        exe(cw(o[4:0], 5'h03, 5'h00, 3'h0, 5'h00, 7'h00));
        rchk("shift_value", ad(OFS_GPR_PAGE, 3), 32'(e.value));
        chk("shift_flags", 32'(flag_register), 32'(e.flags));
      end
    end
    for (int b = 0; b < 8; b++) begin
      wr(OFS_FLAGS, 32'h0000_0000);
      exe(cw(OP_FLAG_SET_GENERIC, 5'h00, 5'h00, b[2:0], 5'h00, 7'h00));
      chk("flag_set", 32'(flag_register), 32'(8'h01 << b));
      wr(OFS_FLAGS, 32'h0000_00FF);
      exe(cw(OP_FLAG_CLEAR_GENERIC, 5'h00, 5'h00, b[2:0], 5'h00, 7'h00));
      chk("flag_clear", 32'(flag_register), 32'(8'(~(8'h01 << b))));
    end
    wr(OFS_FLAGS, 32'h0000_007F);
    exe(cw(OP_GLOBAL_IRQ_ON, 5'h00, 5'h00, 3'h0, 5'h00, 7'h00));
    chk("irq_on", 32'(flag_register), 32'h0000_00FF);
    exe(cw(OP_GLOBAL_IRQ_OFF, 5'h00, 5'h00, 3'h0, 5'h00, 7'h00));
    chk("irq_off", 32'(flag_register), 32'h0000_007F);
    wr(ad(OFS_GPR_PAGE, 5), 32'h0000_0020);
    wr(OFS_FLAGS, 32'h0000_0000);
    exe(cw(OP_BIT_TO_TRANSFER_FLAG, 5'h00, 5'h05, 3'h5, 5'h00, 7'h00));
    chk("t_from_one", 32'(flag_register), 32'h0000_0040);
    wr(OFS_FLAGS, 32'h0000_00FF);
    exe(cw(OP_BIT_TO_TRANSFER_FLAG, 5'h00, 5'h05, 3'h4, 5'h00, 7'h00));
    chk("t_from_zero", 32'(flag_register), 32'h0000_00BF);
    wr(ad(OFS_GPR_PAGE, 6), 32'h0000_00F0);
    exe(cw(OP_TRANSFER_FLAG_TO_BIT, 5'h06, 5'h00, 3'h5, 5'h00, 7'h00));
    rchk("t_zero_to_bit", ad(OFS_GPR_PAGE, 6), 32'h0000_00D0);
    wr(OFS_FLAGS, 32'h0000_0040);
    exe(cw(OP_TRANSFER_FLAG_TO_BIT, 5'h06, 5'h00, 3'h2, 5'h00, 7'h00));
    rchk("t_one_to_bit", ad(OFS_GPR_PAGE, 6), 32'h0000_00D4);
    chk("t_flags_kept", 32'(flag_register), 32'h0000_0040);
    wr(OFS_FLAGS, 32'h0000_005A);
    wr(ad(OFS_GPR_PAGE, 7), 32'h0000_00A5);
    exe(cw(OP_REG_COPY, 5'h08, 5'h07, 3'h0, 5'h00, 7'h00));
    rchk("copy", ad(OFS_GPR_PAGE, 8), 32'h0000_00A5);
    wr(ad(OFS_GPR_PAGE, 10), 32'h0000_0012);
    wr(ad(OFS_GPR_PAGE, 11), 32'h0000_0034);
    exe(cw(OP_REG_PAIR_COPY, 5'h0D, 5'h0B, 3'h0, 5'h00, 7'h00));
    rchk("pair_low", ad(OFS_GPR_PAGE, 12), 32'h0000_0012);
    rchk("pair_high", ad(OFS_GPR_PAGE, 13), 32'h0000_0034);
    // second command follows at once and must stall behind the two-cycle one
    wr(ad(OFS_IO_PAGE, 4), 32'h0000_0011);
    xfer(1'b1, OFS_CMD, cw(OP_IO_BIT_SET, 5'h00, 5'h00, 3'h7, 5'h04, 7'h00), 1'b1);
    exe(cw(OP_IO_BIT_CLEAR, 5'h00, 5'h00, 3'h0, 5'h04, 7'h00));
    rchk("io_set_clear", ad(OFS_IO_PAGE, 4), 32'h0000_0090);
    rchk("io_cycles", OFS_STATUS, 32'h0000_0008);
    chk("io_flags", 32'(flag_register), 32'h0000_005A);
    for (int o = 1; o < 4; o++) begin
      for (int i = 0; i < 2; i++) begin
        f = i[0] ? 8'h88 : 8'h00;
        t = (o == 1) ? !f[FLG_V] : (o == 2) ? f[FLG_I] : !f[FLG_I];
        wr(OFS_PC, 32'h0000_0100);
        wr(OFS_FLAGS, 32'(f));
        exe(cw(o[4:0], 5'h00, 5'h00, 3'h0, 5'h00, i[0] ? 7'h05 : 7'h7E));
        rchk("branch_pc", OFS_PC, t ? (i[0] ? 32'h0000_0106 : 32'h0000_00FF) : 32'h0000_0101);
        rchk("branch_status", OFS_STATUS, t ? 32'h0000_000A : 32'h0000_0004);
        chk("branch_flags", 32'(flag_register), 32'(f));
      end
    end
    // nop and the unused codes only step the counter
    wr(OFS_PC, 32'h0000_0200);
    exe(cw(OP_NOP, 5'h00, 5'h00, 3'h0, 5'h00, 7'h05));
    exe(cw(5'h1F, 5'h03, 5'h00, 3'h1, 5'h00, 7'h05));
    rchk("nop_pc", OFS_PC, 32'h0000_0202);
    chk("nop_pc_out", 32'(pc_out), 32'h0000_0202);
    rchk("nop_status", OFS_STATUS, 32'h0000_0004);
    rchk("cmd_readback", OFS_CMD, 32'h0280_807F);
    chk("nop_flags", 32'(flag_register), 32'h0000_0088);
    conclude();
  end
endmodule
